// ### rtl/dcw_regs.svh
/*
  Bit positions and reset values of the drive command word and the
  drive state report word.
  Assumes inclusion by bare name from design files only.
*/
`ifndef DCW_REGS_SVH
`define DCW_REGS_SVH

// ------------------------------------------------------------------
// Command word fields
// ------------------------------------------------------------------
`define DCW_C_OFF1        0
`define DCW_C_OFF2        1
`define DCW_C_OFF3        2
`define DCW_C_COAST       3
`define DCW_C_QSTOP       4
`define DCW_C_HOLD        5
`define DCW_C_START       6
`define DCW_C_RESET       7
`define DCW_C_JOG1        8
`define DCW_C_JOG2        9
`define DCW_C_VALID       10
`define DCW_C_SLOW        11
`define DCW_C_CATCH       12
`define DCW_C_SET_LO      13
`define DCW_C_SET_HI      14
`define DCW_C_REV         15
`define DCW_CMD_RESET     16'h0000

// ------------------------------------------------------------------
// Report word fields
// ------------------------------------------------------------------
`define DCW_S_CTL_RDY     0
`define DCW_S_DRV_RDY     1
`define DCW_S_ENABLE      2
`define DCW_S_TRIP        3
`define DCW_S_ON2         4
`define DCW_S_ON3         5
`define DCW_S_NO_START    6
`define DCW_S_WARN        7
`define DCW_S_AT_REF      8
`define DCW_S_BUS_CTL     9
`define DCW_S_IN_LIMIT    10
`define DCW_STAT_RESET    16'h0040

// ------------------------------------------------------------------
// Option codes
// ------------------------------------------------------------------
`define DCW_RELAY_OPT     8'h1F
`define DCW_MULTI_SETUP   8'h09
`define DCW_PROFILE_OPT   8'h01
`define DCW_SETUP_RESET   2'h0

`endif

// ### rtl/dcw_pkg.sv
/*
  Types shared by the command word interpreter.
  Assumes nothing of its surroundings.
*/
package dcw_pkg;

  // Reversing source selection
  typedef enum logic [1:0] {
    DCW_REV_DIGITAL = 2'h0,
    DCW_REV_SERIAL  = 2'h1,
    DCW_REV_OR      = 2'h2,
    DCW_REV_AND     = 2'h3
  } dcw_rev_src_t;

  // Drive sequencing state, one-hot
  typedef enum logic [3:0] {
    DCW_ST_INHIBIT = 4'b0001,
    DCW_ST_READY   = 4'b0010,
    DCW_ST_RUN     = 4'b0100,
    DCW_ST_TRIP    = 4'b1000
  } dcw_state_t;

endpackage

// ### rtl/dcw_sync.sv
/*
  Two-flip-flop synchroniser, one per bit.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module dcw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          dout[i]   <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// ### rtl/dcw_interp.sv
/*
  Drive command word interpreter: takes whole command words from the
  fieldbus side, turns them into drive controls and builds the drive
  state report word.
  Assumes cmd_wr and drive-side status come from logic on core_clk;
  keypad, site and digital reverse arrive from pins.
*/
`timescale 1ns/1ps
`include "dcw_regs.svh"
module dcw_interp
  import dcw_pkg::*;
#(
  parameter int REF_W = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fieldbus word port
  input  wire logic [15:0]      cmd_word,
  input  wire logic             cmd_wr,
  output logic      [15:0]      drive_state_report_word,
  // Configuration
  input  wire logic [7:0]       relay_func,
  input  wire logic [7:0]       active_setup_mode,
  input  wire logic             setups_linked,
  input  wire dcw_rev_src_t     rev_src,
  input  wire logic [7:0]       word_profile,
  input  wire logic [REF_W-1:0] adjust_amount,
  input  wire logic [REF_W-1:0] warn_speed_low,
  input  wire logic [REF_W-1:0] warn_speed_high,
  // Drive status
  input  wire logic             trip_in,
  input  wire logic             warning_in,
  input  wire logic             power_ok,
  input  wire logic [REF_W-1:0] speed_ref_in,
  input  wire logic [REF_W-1:0] motor_speed,
  input  wire logic [REF_W-1:0] out_freq,
  // Pins
  input  wire logic             local_keypad_stop,
  input  wire logic             local_ref_site,
  input  wire logic             dig_reverse,
  // Drive controls
  output logic                  ramp_stop,
  output logic                  coast_stop,
  output logic                  quick_stop,
  output logic                  start_enable,
  output logic                  hold_freq,
  output logic                  drive_reset,
  output logic                  fault_ack,
  output logic                  jog1,
  output logic                  jog2,
  output logic      [REF_W-1:0] freq_ref,
  output logic      [1:0]       active_setup,
  output logic                  reverse,
  output logic                  relay_on,
  output dcw_state_t            drive_state
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       key_stop_s;
  logic       site_local_s;
  logic       dig_rev_s;

  dcw_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk  (core_clk),
    .rst  (rst),
    .din  ({dig_reverse, local_ref_site, local_keypad_stop}),
    .dout (pins_s)
  );

  assign key_stop_s   = pins_s[0];
  assign site_local_s = pins_s[1];
  assign dig_rev_s    = pins_s[2];

  // ----------------------------------------------------------------
  // Command word capture
  // ----------------------------------------------------------------
  logic [15:0] cw;
  logic        word_taken;
  logic        reset_edge;

  assign word_taken = cmd_wr && cmd_word[`DCW_C_VALID];

  // Whole word taken in one edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cw <= `DCW_CMD_RESET;
    end else if (word_taken) begin
      cw <= cmd_word;
    end
  end

  // Leading edge of the reset bit between accepted words
  assign reset_edge = word_taken && cmd_word[`DCW_C_RESET]
                      && !cw[`DCW_C_RESET];

  // ----------------------------------------------------------------
  // Decoded command terms
  // ----------------------------------------------------------------
  logic off1;
  logic off2;
  logic off3;
  logic all_on;
  logic stop_req;
  logic zero_freq;

  assign off1      = !cw[`DCW_C_OFF1];
  assign off2      = !cw[`DCW_C_OFF2];
  assign off3      = !cw[`DCW_C_OFF3];
  assign all_on    = !off1 && !off2 && !off3;
  assign stop_req  = off1 || off2 || off3 || !cw[`DCW_C_START];
  assign zero_freq = (out_freq == '0);

  // ----------------------------------------------------------------
  // Trip latch
  // ----------------------------------------------------------------
  logic tripped;

  // A new trip wins over a reset arriving in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tripped <= 1'b0;
    end else if (trip_in) begin
      tripped <= 1'b1;
    end else if (reset_edge) begin
      tripped <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  dcw_state_t state;
  dcw_state_t next_state;
  logic       start_ok;

  assign start_ok = all_on && cw[`DCW_C_COAST] && cw[`DCW_C_QSTOP]
                    && cw[`DCW_C_START] && !tripped;

  always_comb begin
    next_state = state;
    case (state)
      DCW_ST_INHIBIT: begin
        if (tripped) begin
          next_state = DCW_ST_TRIP;
        end else if (all_on) begin
          next_state = DCW_ST_READY;
        end
      end
      DCW_ST_READY: begin
        if (tripped) begin
          next_state = DCW_ST_TRIP;
        end else if (!all_on) begin
          next_state = DCW_ST_INHIBIT;
        end else if (start_ok) begin
          next_state = DCW_ST_RUN;
        end
      end
      DCW_ST_RUN: begin
        if (tripped) begin
          next_state = DCW_ST_TRIP;
        end else if (!start_ok && zero_freq) begin
          next_state = DCW_ST_READY;
        end
      end
      DCW_ST_TRIP: begin
        if (!tripped) begin
          next_state = DCW_ST_INHIBIT;
        end
      end
      default: next_state = DCW_ST_INHIBIT;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= DCW_ST_INHIBIT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Stop and start controls
  // ----------------------------------------------------------------
  logic coast_any;

  assign coast_any = off2 || !cw[`DCW_C_COAST] || tripped;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ramp_stop    <= 1'b1;
      coast_stop   <= 1'b1;
      quick_stop   <= 1'b0;
      start_enable <= 1'b0;
      hold_freq    <= 1'b1;
      drive_state  <= DCW_ST_INHIBIT;
    end else begin
      coast_stop   <= coast_any;
      quick_stop   <= !coast_any
                      && (off3 || !cw[`DCW_C_QSTOP]);
      ramp_stop    <= !coast_any && !off3 && cw[`DCW_C_QSTOP]
                      && (off1 || !cw[`DCW_C_START]);
      start_enable <= start_ok;
      hold_freq    <= !cw[`DCW_C_HOLD];
      drive_state  <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse, relay, jog
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_reset <= 1'b0;
      fault_ack   <= 1'b0;
      relay_on    <= 1'b0;
      jog1        <= 1'b0;
      jog2        <= 1'b0;
    end else begin
      drive_reset <= reset_edge;
      fault_ack   <= reset_edge;
      relay_on    <= (relay_func == `DCW_RELAY_OPT) && stop_req
                     && zero_freq;
      jog1        <= cw[`DCW_C_JOG1] && !cw[`DCW_C_QSTOP]
                     && all_on && cw[`DCW_C_COAST];
      jog2        <= cw[`DCW_C_JOG2] && !cw[`DCW_C_QSTOP]
                     && all_on && cw[`DCW_C_COAST];
    end
  end

  // ----------------------------------------------------------------
  // Frequency reference with slow-down, catch-up and hold
  // ----------------------------------------------------------------
  logic [REF_W-1:0] next_freq_ref;

  always_comb begin
    if (cw[`DCW_C_SLOW]) begin
      next_freq_ref = speed_ref_in - adjust_amount;
    end else if (cw[`DCW_C_CATCH]) begin
      next_freq_ref = speed_ref_in + adjust_amount;
    end else begin
      next_freq_ref = speed_ref_in;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      freq_ref <= '0;
    end else if (cw[`DCW_C_HOLD]) begin
      freq_ref <= next_freq_ref;
    end
  end

  // ----------------------------------------------------------------
  // Set-up selection
  // ----------------------------------------------------------------
  logic setup_change_ok;

  assign setup_change_ok = (active_setup_mode == `DCW_MULTI_SETUP)
                           && (state != DCW_ST_RUN
                               || setups_linked);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_setup <= `DCW_SETUP_RESET;
    end else if (setup_change_ok) begin
      active_setup <= {cw[`DCW_C_SET_HI], cw[`DCW_C_SET_LO]};
    end
  end

  // ----------------------------------------------------------------
  // Reversing
  // ----------------------------------------------------------------
  logic next_reverse;

  always_comb begin
    case (rev_src)
      DCW_REV_SERIAL: next_reverse = cw[`DCW_C_REV];
      DCW_REV_OR:     next_reverse = cw[`DCW_C_REV] || dig_rev_s;
      DCW_REV_AND:    next_reverse = cw[`DCW_C_REV] && dig_rev_s;
      default:        next_reverse = dig_rev_s;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reverse <= 1'b0;
    end else begin
      reverse <= next_reverse;
    end
  end

  // ----------------------------------------------------------------
  // Start-not-possible flag
  // ----------------------------------------------------------------
  logic no_start;
  logic no_start_set;
  logic no_start_clr;

  assign no_start_set = reset_edge || off2 || off3;
  assign no_start_clr = off1 && !off2 && !off3 && cw[`DCW_C_VALID];

  // Set at power-up by reset value; set wins over clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      no_start <= 1'b1;
    end else if (no_start_set) begin
      no_start <= 1'b1;
    end else if (no_start_clr) begin
      no_start <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Report word, built whole and registered at once
  // ----------------------------------------------------------------
  logic [15:0] next_report;

  always_comb begin
    next_report = 16'h0000;
    next_report[`DCW_S_CTL_RDY]  = all_on && !tripped;
    next_report[`DCW_S_DRV_RDY]  = all_on && !tripped && power_ok;
    next_report[`DCW_S_ENABLE]   = all_on && !tripped
                                   && cw[`DCW_C_COAST];
    next_report[`DCW_S_TRIP]     = tripped;
    next_report[`DCW_S_ON2]      = cw[`DCW_C_OFF2];
    next_report[`DCW_S_ON3]      = cw[`DCW_C_OFF3];
    next_report[`DCW_S_NO_START] = (word_profile == `DCW_PROFILE_OPT)
                                   && no_start;
    next_report[`DCW_S_WARN]     = warning_in;
    next_report[`DCW_S_AT_REF]   = (motor_speed == freq_ref);
    next_report[`DCW_S_BUS_CTL]  = !key_stop_s && !site_local_s;
    next_report[`DCW_S_IN_LIMIT] = (out_freq >= warn_speed_low)
                                   && (out_freq <= warn_speed_high);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_state_report_word <= `DCW_STAT_RESET;
    end else begin
      drive_state_report_word <= next_report;
    end
  end

endmodule

// ### tb/dcw_master_model.sv
/*
  Fieldbus master model: sends whole command words on the word port.
  Assumes it is called just after a falling edge of core_clk.
*/
`timescale 1ns/1ps
module dcw_master_model (
  // Clock
  input  wire logic        core_clk,
  // Word port
  output logic      [15:0] cmd_word,
  output logic             cmd_wr
);
  initial begin
    cmd_word = 16'h0000;
    cmd_wr   = 1'h0;
  end

  // Back-to-back words keep the strobe high; once released the word
  // lines show the inverse so a stale word cannot pass for a new one
  task automatic put(input logic [15:0] ws[$]);
    foreach (ws[i]) begin
      cmd_word = ws[i];
      cmd_wr   = 1'h1;
      @(negedge core_clk);
    end
    cmd_wr   = 1'h0;
    cmd_word = ~cmd_word;
  endtask
endmodule

// ### tb/dcw_interp_properties.sv
/*
  Port checks of the command word interpreter.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module dcw_interp_properties #(
  parameter int REF_W = 16
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst,
  // Watched ports
  input wire logic [15:0]      cmd_word,
  input wire logic             cmd_wr,
  input wire logic [15:0]      drive_state_report_word,
  input wire logic [7:0]       relay_func,
  input wire logic [7:0]       active_setup_mode,
  input wire logic [REF_W-1:0] out_freq,
  input wire logic             coast_stop,
  input wire logic             quick_stop,
  input wire logic             ramp_stop,
  input wire logic             hold_freq,
  input wire logic             drive_reset,
  input wire logic             jog1,
  input wire logic [1:0]       active_setup,
  input wire logic             relay_on
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic        acc;
  logic [15:0] w1, w2, rw;
  assign acc = cmd_wr && cmd_word[10];
  assign rw  = drive_state_report_word;
  always_ff @(posedge core_clk) begin
    w1 <= cmd_word;
    w2 <= w1;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_off_mirror: assert property (
    acc |-> ##2 rw[5:4] == w2[2:1]) else $error("report 5:4 wrong");
  a_hold_follow: assert property (
    acc |-> ##2 hold_freq == !w2[5]) else $error("hold wrong");
  a_jog_gate: assert property (
    acc |-> ##2 jog1 == (w2[8] && !w2[4] && &w2[3:0]))
    else $error("jog1 wrong");
  a_setup_select: assert property (
    acc && active_setup_mode == 8'h09 |-> ##2 active_setup == w2[14:13])
    else $error("set-up wrong");
  a_reset_cause: assert property (
    $rose(drive_reset) |-> $past(acc) && w1[7])
    else $error("reset pulse without cause");
  a_reset_pulse: assert property (
    drive_reset |=> !drive_reset) else $error("reset pulse too long");
  a_coast_prio: assert property (
    acc && !cmd_word[1] |-> ##2 coast_stop && !quick_stop && !ramp_stop)
    else $error("coast stop wrong");
  a_trip_ready: assert property (
    rw[3] |-> !rw[0] && !rw[2]) else $error("ready while tripped");
  a_relay_zero: assert property (
    relay_on |-> $past(out_freq) == '0 && relay_func == 8'h1F)
    else $error("relay on while turning");
  a_ignore_word: assert property (
    !acc ##1 !acc |=> $stable(hold_freq) && $stable(jog1)
      && $stable(active_setup)) else $error("controls moved");

  c_reset: cover property (drive_reset);
  c_jog: cover property (jog1);
  c_trip: cover property (rw[3]);
  c_relay: cover property (relay_on);
endmodule

bind dcw_interp dcw_interp_properties #(.REF_W(REF_W)) i_props (
  .core_clk, .rst, .cmd_word, .cmd_wr, .drive_state_report_word,
  .relay_func, .active_setup_mode, .out_freq, .coast_stop, .quick_stop,
  .ramp_stop, .hold_freq, .drive_reset, .jog1, .active_setup, .relay_on);

// ### tb/test_drive_control_word_interpreter.sv
/*
  Bench for the command word interpreter: model, scoreboard, scenarios.
  Assumes the master model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module test_drive_control_word_interpreter
  import dcw_pkg::*;
;
  localparam logic [47:0] MSK = 48'h1FFF_FFFF_07FD;
  logic         core_clk, rst, cmd_wr, trip_in, warning_in;
  logic         local_keypad_stop, local_ref_site, dig_reverse;
  logic [15:0]  cmd_word, drive_state_report_word, freq_ref;
  logic [15:0]  speed_ref_in, motor_speed, out_freq, cw, fr, w;
  logic [7:0]   relay_func, active_setup_mode, word_profile;
  logic [1:0]   active_setup, su;
  logic         ramp_stop, coast_stop, quick_stop, start_enable;
  logic         hold_freq, drive_reset, fault_ack, jog1, jog2;
  logic         reverse, relay_on, tr, s6, dr_q, fa_q;
  logic [1:0]   pend;
  logic [47:0]  obs, exp_q[$];
  dcw_rev_src_t rev_src;
  dcw_state_t   drive_state;
  int           n_errors, num_checks;

  assign obs = {3'h0, start_enable, freq_ref, relay_on, reverse,
    active_setup, jog2, jog1, fa_q, dr_q, hold_freq, ramp_stop, quick_stop,
    coast_stop, drive_state_report_word};

  dcw_interp i_dut (
    .core_clk, .rst, .cmd_word, .cmd_wr, .drive_state_report_word,
    .relay_func, .active_setup_mode, .setups_linked(1'h1), .rev_src,
    .word_profile, .adjust_amount(16'h0100), .warn_speed_low(16'h0000),
    .warn_speed_high(16'h2000), .trip_in, .warning_in, .power_ok(1'h1),
    .speed_ref_in, .motor_speed, .out_freq, .local_keypad_stop,
    .local_ref_site, .dig_reverse, .ramp_stop, .coast_stop, .quick_stop,
    .start_enable, .hold_freq, .drive_reset, .fault_ack, .jog1, .jog2,
    .freq_ref, .active_setup, .reverse, .relay_on, .drive_state);
  dcw_master_model i_master (.core_clk, .cmd_word, .cmd_wr);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Model: expected controls and report word for one sent word
  // ------------------------------------------------------------
  task automatic push(input logic [15:0] v);
    logic        rs;
    logic [15:0] fo;
    logic [47:0] e;
    rs = v[10] && v[7] && !cw[7];
    // Start-not-possible and the at-reference compare lag by one word
    if (rs || !cw[1] || !cw[2]) s6 = 1'h1;
    else if (!cw[0]) s6 = 1'h0;
    fo = fr;
    if (v[10]) begin
      if (rs && !trip_in) tr = 1'h0;
      cw = v;
      if (active_setup_mode == 8'h09) su = v[14:13];
    end
    if (cw[5]) fr = speed_ref_in + (cw[11] ? -16'h0100 :
      (cw[12] ? 16'h0100 : 16'h0000));
    e = '0;
    e[0] = &cw[2:0] && !tr;
    e[2] = &cw[3:0] && !tr;
    e[6:3] = {s6 && word_profile == 8'h01, cw[2:1], tr};
    e[10:7] = {out_freq <= 16'h2000, !local_keypad_stop && !local_ref_site,
      motor_speed == fo, warning_in};
    e[16] = !cw[1] || !cw[3] || tr;
    e[17] = !e[16] && !(cw[2] && cw[4]);
    e[18] = !e[16] && !e[17] && !(cw[0] && cw[6]);
    e[19] = !cw[5];
    e[21:20] = {2{rs}};
    e[23:22] = cw[9:8] & {2{!cw[4] && &cw[3:0]}};
    e[25:24] = su;
    case (rev_src)
      DCW_REV_DIGITAL: e[26] = dig_reverse;
      DCW_REV_SERIAL:  e[26] = cw[15];
      DCW_REV_OR:      e[26] = cw[15] | dig_reverse;
      default:         e[26] = cw[15] & dig_reverse;
    endcase
    e[27] = relay_func == 8'h1F && out_freq == '0
      && !(&{cw[6], cw[2:0]});
    e[43:28] = fr;
    e[44] = &cw[4:0] && cw[6] && !tr;
    exp_q.push_back(e);
  endtask

  task automatic send(input logic [15:0] ws[$]);
    foreach (ws[i]) push(ws[i]);
    i_master.put(ws);
    repeat (3) @(negedge core_clk);
  endtask

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(input logic [47:0] got, input logic [47:0] want);
    num_checks++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Results stand one edge after the edge that took the word; the reset
  // pulses come one edge earlier and are delayed here to line up
  always @(posedge core_clk) pend <= {pend[0], cmd_wr};
  always @(posedge core_clk) {dr_q, fa_q} <= {drive_reset, fault_ack};
  always @(negedge core_clk) begin
    if (pend[1] === 1'h1) begin
      if (exp_q.size() == 0) check('0, '1);
      else check(obs & MSK, exp_q.pop_front() & MSK);
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    {trip_in, warning_in, tr, pend, su, cw, fr} = '0;
    {local_keypad_stop, local_ref_site, dig_reverse} = '0;
    {n_errors, num_checks} = '0;
    s6 = 1'h1;
    relay_func = 8'h1F;
    active_setup_mode = 8'h09;
    word_profile = 8'h01;
    rev_src = DCW_REV_SERIAL;
    speed_ref_in = 16'h1000;
    motor_speed = 16'h1000;
    out_freq = 16'h0100;
    void'($urandom(32'h3875_8a91));
    repeat (5) @(negedge core_clk);
    check(obs, 48'h0000_000D_0040);
    rst = 1'h0;
    send('{16'h04FF, 16'h04FF, 16'h00BE, 16'h056F, 16'h066F});
    send('{16'h0C7F, 16'h147F, 16'h1C7F, 16'h047E, 16'h047D, 16'h047B});
    for (int i = 0; i < 5; i++) begin
      active_setup_mode = i > 0 ? 8'h09 : 8'h00;
      send('{16'h047F | 16'((i + 1) % 4) << 13});
    end
    dig_reverse = 1'h1;
    for (int i = 0; i < 4; i++) begin
      rev_src = dcw_rev_src_t'(i);
      repeat (3) @(negedge core_clk);
      send('{16'h847F, 16'h047F});
    end
    {dig_reverse, out_freq} = {1'h0, 16'h0000};
    send('{16'h047E, 16'h047F});
    {relay_func, word_profile} = 16'h0000;
    send('{16'h047D, 16'h047E});
    {relay_func, word_profile} = 16'h1F01;
    out_freq = 16'h3000;
    send('{16'h047F});
    out_freq = 16'h0100;
    for (int i = 1; i < 5; i++) begin
      {local_keypad_stop, local_ref_site} = 2'(i);
      repeat (3) @(negedge core_clk);
      send('{16'h047F});
    end
    {trip_in, tr} = 2'h3;
    repeat (4) @(negedge core_clk);
    check(48'(drive_state), 48'(DCW_ST_TRIP));
    send('{16'h04FF, 16'h047F});
    trip_in = 1'h0;
    send('{16'h047F, 16'h04FF, 16'h047F});
    for (int i = 0; i < 30; i++) begin
      w = 16'($urandom);
      warning_in = w[3];
      motor_speed = speed_ref_in ^ {15'h0000, w[2]};
      send('{w, 16'($urandom)});
    end
    check(48'(exp_q.size()), 48'h0);
    print_verdict();
  end
endmodule
